// File: hdl/seeb_map.vh
// constants of the serial eeprom bus slave: widths, fields, reset values, timing
// assumes inclusion by bare name from the design files of this block
`ifndef SEEB_MAP_VH
`define SEEB_MAP_VH

// memory organisation
`define SEEB_ADDR_W 13
`define SEEB_MEM_BYTES 8192
`define SEEB_ROW_W 5
`define SEEB_ROW_BYTES 32
`define SEEB_HI_FIELD_W 5
`define SEEB_MEM_INIT 8'hff

// device select byte fields
`define SEEB_SEL_TYPE_MSB 7
`define SEEB_SEL_TYPE_LSB 4
`define SEEB_SEL_CS_MSB 3
`define SEEB_SEL_CS_LSB 1
`define SEEB_SEL_RW_BIT 0
`define SEEB_DEV_TYPE_RST 4'ha

// bit slots within a byte frame
`define SEEB_BIT_LAST 4'h7
`define SEEB_BIT_ACK 4'h8

// write path buffer
`define SEEB_FIFO_DEPTH 8
`define SEEB_FIFO_WIDTH 21

// timing: program cycle time in ns, clock period in ns
`define SEEB_PROG_TIME_NS 10000000
`define SEEB_CLK_PERIOD_NS 4
`define SEEB_PROG_CYCLES (`SEEB_PROG_TIME_NS / `SEEB_CLK_PERIOD_NS)

`endif

// File: hdl/seeb_sync.v
// two flip-flop synchroniser for levels arriving from pins
// assumes the inputs are quasi-static against ref_clk
`timescale 1ns/100ps
`default_nettype none

module seeb_sync
#(
    parameter WIDTH = 1
)
(
    input wire ref_clk,
    input wire rst_b,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);

reg [WIDTH-1:0] meta_q;

// first stage is read only by the second
always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        meta_q <= {WIDTH{1'b0}};
        q <= {WIDTH{1'b0}};
    end
    else
    begin
        meta_q <= d;
        q <= meta_q;
    end
end

endmodule // seeb_sync

`default_nettype wire

// File: hdl/seeb_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes one clock; full and empty are exact
`timescale 1ns/100ps
`default_nettype none

module seeb_fifo
#(
    parameter WIDTH = 21,
    parameter DEPTH = 8,
    parameter AW = 3
)
(
    input wire ref_clk,
    input wire rst_b,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem_q [0:DEPTH-1];
reg [AW-1:0] wr_q;
reg [AW-1:0] rd_q;
reg [AW:0] cnt_q;
wire push;
wire pop;

// flags straight from the occupancy count
assign in_ready = (cnt_q != DEPTH[AW:0]);
assign out_valid = (cnt_q != {(AW+1){1'b0}});
assign out_data = mem_q[rd_q];
assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;

// storage has no reset, only pointers and count do
always @(posedge ref_clk)
begin
    if (push)
        mem_q[wr_q] <= in_data;
end

// pointers wrap at depth, which need not be a power of two
always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        wr_q <= {AW{1'b0}};
        rd_q <= {AW{1'b0}};
        cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
        if (push)
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
        if (pop)
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
        if (push & ~pop)
            cnt_q <= cnt_q + 1'b1;
        else if (pop & ~push)
            cnt_q <= cnt_q - 1'b1;
    end
end

endmodule // seeb_fifo

`default_nettype wire

// File: hdl/seeb_slave.v
// two-wire serial bus slave of an 8192 byte eeprom, oversampling the bus on ref_clk
// assumes ref_clk far faster than the bus clock; bus pins are open drain outside
// Functional notes
// - memory address arrives as two bytes, high byte first, then low byte.
// - high byte bits 4..0 pick one of 32 blocks; top three bits ignored.
// - write select is acknowledged, then exactly two address bytes precede data.
// - inhibit pin high from start to second address byte blocks writes, nacks data.
// - single byte write is one acknowledged data byte followed by stop.
// - page write stores 1 to 32 bytes of one row in one cycle.
// - write address increments only in its low five bits, wrapping in row.
// - stop starts programming only in the slot right after an acknowledge.
// - during programming all bus inputs are ignored, select included.
// - select during programming gets no acknowledge; afterwards it is accepted.
// - every memory byte starts as all ones.
// - thirteen bit address counter increments after each byte read.
// - read select is acknowledged, byte at counter sent, counter incremented.
// - master acknowledge of a read byte brings the next consecutive byte.
// - read counter wraps from last address to first without pause.
// - read waits for acknowledge in ninth slot; none means standby.
// - select byte is type code, three chip select bits, direction bit.
// - transmitter releases data after eight bits; receiver pulls low in ninth.
`timescale 1ns/100ps
`default_nettype none
`include "seeb_map.vh"

module seeb_slave
#(
    parameter [3:0] DEV_TYPE = `SEEB_DEV_TYPE_RST,
    parameter PROG_CYCLES = `SEEB_PROG_CYCLES,
    parameter CNT_W = 24
)
(
    input wire ref_clk,
    input wire rst_b,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_b,
    input wire [2:0] chip_select_pins,
    input wire write_inhibit_pin,
    output reg prog_busy
);
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_SEL = 3'h1;
localparam [2:0] ST_AHI = 3'h2;
localparam [2:0] ST_ALO = 3'h3;
localparam [2:0] ST_WDAT = 3'h4;
localparam [2:0] ST_RDAT = 3'h5;
localparam [CNT_W-1:0] PROG_LAST = PROG_CYCLES[CNT_W-1:0] - 1'b1;
// synchronised pins
wire scl_s;
wire sda_s;
wire wi_s;
wire [2:0] cs_s;
reg scl_prev_q;
reg sda_prev_q;
reg [2:0] state_q;
reg [2:0] next_q;
reg [3:0] bitcnt_q;
reg [7:0] shreg_q;
reg [7:0] tx_q;
reg [7:0] rd_q;
reg mack_q;
reg inhibit_q;
reg [`SEEB_ADDR_W-1:0] addr_q;
reg [CNT_W-1:0] timer_q;
reg [5:0] cidx_q;
reg [7:0] page_q [0:`SEEB_ROW_BYTES-1];
reg [`SEEB_ROW_BYTES-1:0] pvalid_q;
reg [`SEEB_ADDR_W-`SEEB_ROW_W-1:0] row_q;
reg [7:0] mem_q [0:`SEEB_MEM_BYTES-1];
reg push_q;
reg [`SEEB_FIFO_WIDTH-1:0] push_data_q;
integer i;
wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;
wire receiving;
wire fifo_in_ready;
wire fifo_out_valid;
wire [`SEEB_FIFO_WIDTH-1:0] fifo_out_data;
wire drain;
wire [`SEEB_ROW_W-1:0] drain_col;
wire commit;
// select byte decode, used for acknowledge and for the next state
function sel_match;
    input [7:0] b;
    input [2:0] cs;
    input [3:0] typ;
    begin
        sel_match = (b[`SEEB_SEL_TYPE_MSB:`SEEB_SEL_TYPE_LSB] == typ) &&
                    (b[`SEEB_SEL_CS_MSB:`SEEB_SEL_CS_LSB] == cs);
    end
endfunction
seeb_sync #(.WIDTH(6)) u_sync
(
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d({scl_i, sda_i, write_inhibit_pin, chip_select_pins}),
    .q({scl_s, sda_s, wi_s, cs_s})
);
// bus conditions found from synchronised levels only
assign scl_rise = scl_s & ~scl_prev_q;
assign scl_fall = ~scl_s & scl_prev_q;
assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
assign receiving = (state_q == ST_SEL) || (state_q == ST_AHI) ||
                   (state_q == ST_ALO) || (state_q == ST_WDAT);

// write bytes pass the fifo into the page latches; drain stalls while programming
assign drain = fifo_out_valid & ~prog_busy;
assign drain_col = fifo_out_data[8+`SEEB_ROW_W-1:8];
assign commit = prog_busy & ~cidx_q[5];

seeb_fifo #(.WIDTH(`SEEB_FIFO_WIDTH), .DEPTH(`SEEB_FIFO_DEPTH), .AW(3)) u_fifo
(
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data_q),
    .out_valid(fifo_out_valid),
    .out_ready(~prog_busy),
    .out_data(fifo_out_data)
);
// delivered content is all ones
initial
begin
    for (i = 0; i < `SEEB_MEM_BYTES; i = i + 1)
        mem_q[i] = `SEEB_MEM_INIT;
end
// array port: commit writes one latch per cycle, read side registers the counter byte
always @(posedge ref_clk)
begin
    if (commit && pvalid_q[cidx_q[4:0]])
        mem_q[{row_q, cidx_q[4:0]}] <= page_q[cidx_q[4:0]];
    rd_q <= mem_q[addr_q];
end

// page latches fill from the fifo
always @(posedge ref_clk)
begin
    if (drain)
        page_q[drain_col] <= fifo_out_data[7:0];
end

// program cycle: commit sweep, then wait out the timer before answering again
always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        prog_busy <= 1'b0;
        timer_q <= {CNT_W{1'b0}};
        cidx_q <= 6'h20;
        pvalid_q <= {`SEEB_ROW_BYTES{1'b0}};
        row_q <= {(`SEEB_ADDR_W-`SEEB_ROW_W){1'b0}};
    end
    else if (prog_busy)
    begin
        if (!cidx_q[5])
            cidx_q <= cidx_q + 1'b1;
        else
            pvalid_q <= {`SEEB_ROW_BYTES{1'b0}};
        if (timer_q == PROG_LAST)
            prog_busy <= 1'b0;
        else
            timer_q <= timer_q + 1'b1;
    end
    else if (stop_det && state_q == ST_WDAT && bitcnt_q == 4'h0 && (pvalid_q != 0 || fifo_out_valid))
    begin
        // only a stop in the slot after an acknowledge programs; others discard
        prog_busy <= 1'b1;
        timer_q <= {CNT_W{1'b0}};
        cidx_q <= 6'h00;
    end
    else if (start_det || stop_det)
        pvalid_q <= {`SEEB_ROW_BYTES{1'b0}};
    else if (drain)
    begin
        pvalid_q[drain_col] <= 1'b1;
        row_q <= fifo_out_data[8+`SEEB_ADDR_W-1:8+`SEEB_ROW_W];
    end
end

// bus protocol engine
always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        scl_prev_q <= 1'b0;
        sda_prev_q <= 1'b0;
        state_q <= ST_IDLE;
        next_q <= ST_IDLE;
        bitcnt_q <= 4'h0;
        shreg_q <= 8'h00;
        tx_q <= 8'h00;
        mack_q <= 1'b0;
        inhibit_q <= 1'b0;
        addr_q <= {`SEEB_ADDR_W{1'b0}};
        push_q <= 1'b0;
        push_data_q <= {`SEEB_FIFO_WIDTH{1'b0}};
        sda_o <= 1'b0;
        sda_oe_b <= 1'b1;
    end
    else
    begin
        scl_prev_q <= scl_s;
        sda_prev_q <= sda_s;
        push_q <= 1'b0;
        sda_o <= 1'b0;
        if (prog_busy)
        begin
            // deaf to the bus, own select included
            state_q <= ST_IDLE;
            sda_oe_b <= 1'b1;
        end
        else if (start_det)
        begin
            // clock fall closing the start is no data bit: count it as a slot end
            state_q <= ST_SEL;
            next_q <= ST_SEL;
            bitcnt_q <= `SEEB_BIT_ACK;
            inhibit_q <= wi_s;
            sda_oe_b <= 1'b1;
        end
        else if (stop_det)
        begin
            state_q <= ST_IDLE;
            sda_oe_b <= 1'b1;
        end
        else
        begin
            // inhibit is watched until the second address byte is complete
            if (wi_s && (state_q == ST_SEL || state_q == ST_AHI || state_q == ST_ALO))
                inhibit_q <= 1'b1;
            if (scl_rise && receiving && bitcnt_q != `SEEB_BIT_ACK)
                shreg_q <= {shreg_q[6:0], sda_s};
            if (scl_rise && state_q == ST_RDAT && bitcnt_q == `SEEB_BIT_ACK)
                mack_q <= ~sda_s;
            if (scl_fall && receiving)
            begin
                if (bitcnt_q < `SEEB_BIT_LAST)
                    bitcnt_q <= bitcnt_q + 1'b1;
                else if (bitcnt_q == `SEEB_BIT_LAST)
                begin
                    bitcnt_q <= `SEEB_BIT_ACK;
                    case (state_q)
                        ST_SEL:
                        begin
                            if (sel_match(shreg_q, cs_s, DEV_TYPE))
                            begin
                                sda_oe_b <= 1'b0;
                                next_q <= shreg_q[`SEEB_SEL_RW_BIT] ? ST_RDAT : ST_AHI;
                            end
                            else
                                next_q <= ST_IDLE;
                        end
                        ST_AHI:
                        begin
                            sda_oe_b <= 1'b0;
                            addr_q[`SEEB_ADDR_W-1:8] <= shreg_q[`SEEB_HI_FIELD_W-1:0];
                            next_q <= ST_ALO;
                        end
                        ST_ALO:
                        begin
                            sda_oe_b <= 1'b0;
                            addr_q[7:0] <= shreg_q;
                            next_q <= ST_WDAT;
                        end
                        ST_WDAT:
                        begin
                            next_q <= ST_WDAT;
                            if (!inhibit_q && fifo_in_ready)
                            begin
                                // a full buffer is refused by withholding acknowledge
                                sda_oe_b <= 1'b0;
                                push_q <= 1'b1;
                                push_data_q <= {addr_q, shreg_q};
                                addr_q[`SEEB_ROW_W-1:0] <= addr_q[`SEEB_ROW_W-1:0] + 1'b1;
                            end
                        end
                        default:
                            next_q <= ST_IDLE;
                    endcase
                end
                else
                begin
                    bitcnt_q <= 4'h0;
                    state_q <= next_q;
                    if (next_q == ST_RDAT)
                    begin
                        // first read byte goes out straight after the select acknowledge
                        tx_q <= rd_q;
                        sda_oe_b <= rd_q[7];
                        addr_q <= addr_q + 1'b1;
                    end
                    else
                        sda_oe_b <= 1'b1;
                end
            end
            else if (scl_fall && state_q == ST_RDAT)
            begin
                if (bitcnt_q < `SEEB_BIT_LAST)
                begin
                    bitcnt_q <= bitcnt_q + 1'b1;
                    tx_q <= {tx_q[6:0], 1'b0};
                    sda_oe_b <= tx_q[6];
                end
                else if (bitcnt_q == `SEEB_BIT_LAST)
                begin
                    bitcnt_q <= `SEEB_BIT_ACK;
                    sda_oe_b <= 1'b1;
                end
                else if (mack_q)
                begin
                    bitcnt_q <= 4'h0;
                    tx_q <= rd_q;
                    sda_oe_b <= rd_q[7];
                    addr_q <= addr_q + 1'b1;
                end
                else
                begin
                    state_q <= ST_IDLE;
                    sda_oe_b <= 1'b1;
                end
            end
        end
    end
end

endmodule // seeb_slave

`default_nettype wire

// File: tb/seeb_slave_properties.sv
// port checker of the eeprom bus slave: drive timing, program cycle, write inhibit
// assumes binding to seeb_slave and PROG_CYCLES handed on from the instance
`timescale 1ns/100ps
`default_nettype none
module seeb_slave_properties
#(
    parameter PROG_CYCLES = 400
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_b,
    input wire logic [2:0] chip_select_pins,
    input wire logic write_inhibit_pin,
    input wire logic prog_busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    logic [23:0] busy_cnt_q;
    logic [9:0] inh_cnt_q;
    // program cycle length and inhibit level age; inhibit saturates so it never wraps
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            busy_cnt_q <= 24'h0;
            inh_cnt_q <= 10'h0;
        end
        else
        begin
            busy_cnt_q <= prog_busy ? busy_cnt_q + 24'h1 : 24'h0;
            inh_cnt_q <= !write_inhibit_pin ? 10'h0 : (&inh_cnt_q ? inh_cnt_q : inh_cnt_q + 10'h1);
        end
    end
    chk_sda_odrain: assert property (sda_o == 1'b0)
        else $error("sda output value not low");
    chk_busy_quiet: assert property (prog_busy |-> sda_oe_b)
        else $error("data line pulled during program cycle");
    chk_busy_bound: assert property (prog_busy |-> int'(busy_cnt_q) <= PROG_CYCLES + 2)
        else $error("program cycle too long");
    chk_busy_length: assert property ($fell(prog_busy) |-> int'(busy_cnt_q) >= PROG_CYCLES - 2)
        else $error("program cycle too short");
    chk_busy_hold: assert property ($rose(prog_busy) |-> prog_busy [*8])
        else $error("program cycle glitch");
    chk_prog_on_stop: assert property ($rose(prog_busy) |-> scl_i && sda_i)
        else $error("program cycle started outside a stop");
    chk_drive_clk_low: assert property ($changed(sda_oe_b) |-> !scl_i)
        else $error("data drive changed while clock high");
    chk_inhibit_noprog: assert property ($rose(prog_busy) |-> inh_cnt_q < 10'h320)
        else $error("program cycle despite inhibit");
endmodule // seeb_slave_properties
`default_nettype wire

// File: tb/seeb_master.sv
// two-wire bus master model: drives the clock and an open drain pull on data
// assumes the bench resolves data with a pull-up; 80 ns bit, ref_clk of 4 ns
`timescale 1ns/100ps
`default_nettype none
module seeb_master
(
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // one quarter bit; entered just after a clock edge
    task automatic step(input logic c, input logic p);
    begin
        scl <= c;
        sda_pull <= p;
        repeat (5) @(posedge ref_clk);
    end
    endtask
    // data changes only while the clock is low
    task automatic bit_slot(input logic p, output logic s);
    begin
        step(1'b0, p);
        step(1'b1, p);
        s = sda;
        step(1'b1, p);
        step(1'b0, p);
    end
    endtask
    // start or repeated start
    task automatic start();
    begin
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    end
    endtask
    // eight bits msb first, then the ninth slot; tx all ones releases for reads
    task automatic xfer(input logic [7:0] tx, input logic m_ack, output logic [7:0] rx, output logic ack);
        logic s;
    begin
        for (int i = 7; i >= 0; i--)
        begin
            bit_slot(~tx[i], s);
            rx[i] = s;
        end
        bit_slot(m_ack, s);
        ack = ~s;
    end
    endtask
    // stop straight after the ninth slot, then bus free
    task automatic stop();
    begin
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
    end
    endtask
endmodule // seeb_master
`default_nettype wire

// File: tb/seeb_slave_tb.sv
// self-checking bench of the eeprom bus slave: refusals, page write, polling, reads
// assumes seeb_master as bus partner and the checker bound below
`timescale 1ns/100ps
`default_nettype none
`include "seeb_map.vh"
module seeb_slave_tb;
    localparam logic [7:0] SEL_W = {`SEEB_DEV_TYPE_RST, 3'h5, 1'b0};
    localparam logic [7:0] SEL_R = SEL_W | 8'h01;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic inhibit = 1'b0;
    logic [2:0] cs_pins = 3'h5;
    logic scl, sda_pull, sda, sda_o, sda_oe_b, prog_busy, ack;
    logic [7:0] rx;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2 ref_clk = ~ref_clk;
    // open drain wire with pull-up
    assign sda = ~(sda_pull | ~sda_oe_b);
    seeb_master i_master (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
    seeb_slave #(.PROG_CYCLES(400)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_b(sda_oe_b), .chip_select_pins(cs_pins), .write_inhibit_pin(inhibit),
        .prog_busy(prog_busy));
    task automatic test_done();
    begin
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
    begin
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // write select and two address bytes, each acknowledged
    task automatic set_addr(input logic [2:0] junk, input logic [12:0] a);
    begin
        i_master.start();
        i_master.xfer(SEL_W, 1'b0, rx, ack);
        check({7'h0, ack}, 8'h01);
        i_master.xfer({junk, a[12:8]}, 1'b0, rx, ack);
        check({7'h0, ack}, 8'h01);
        i_master.xfer(a[7:0], 1'b0, rx, ack);
        check({7'h0, ack}, 8'h01);
    end
    endtask
    task automatic rd_select();
    begin
        i_master.start();
        i_master.xfer(SEL_R, 1'b0, rx, ack);
        check({7'h0, ack}, 8'h01);
    end
    endtask
    // one read byte; no master ack ends the read
    task automatic rd(input logic [7:0] exp, input logic more);
    begin
        i_master.xfer(8'hff, more, rx, ack);
        check(rx, exp);
        if (!more)
            i_master.stop();
    end
    endtask
    task automatic t_refuse_blank();
        logic [7:0] bad [2];
    begin
        bad = '{{4'h5, 3'h5, 1'b0}, {`SEEB_DEV_TYPE_RST, 3'h2, 1'b1}};
        for (int i = 0; i < 2; i++)
        begin
            i_master.start();
            i_master.xfer(bad[i], 1'b0, rx, ack);
            check({7'h0, ack}, 8'h00);
            i_master.stop();
        end
        set_addr(3'h0, 13'h0123);
        rd_select();
        rd(8'hff, 1'b0);
    end
    endtask
    // page write wrapping in the last row, polling, then reads across the top
    task automatic t_page();
        int polls;
    begin
        polls = 0;
        set_addr(3'h7, 13'h1ffe);
        for (int i = 0; i < 4; i++)
        begin
            i_master.xfer(8'ha0 + i[7:0], 1'b0, rx, ack);
            check({7'h0, ack}, 8'h01);
        end
        i_master.stop();
        check({7'h0, prog_busy}, 8'h01);
        ack = 1'b0;
        while (!ack && polls < 10)
        begin
            i_master.start();
            i_master.xfer(SEL_W, 1'b0, rx, ack);
            polls++;
        end
        check({7'h0, polls > 1}, 8'h01);
        check({7'h0, ack}, 8'h01);
        i_master.xfer(8'h1f, 1'b0, rx, ack);
        i_master.xfer(8'he0, 1'b0, rx, ack);
        rd_select();
        rd(8'ha2, 1'b1);
        rd(8'ha3, 1'b1);
        rd(8'hff, 1'b0);
        set_addr(3'h0, 13'h1ffe);
        rd_select();
        rd(8'ha0, 1'b0);
        rd_select();
        rd(8'ha1, 1'b1);
        rd(8'hff, 1'b0);
    end
    endtask
    task automatic t_inhibit();
    begin
        inhibit <= 1'b1;
        repeat (100) @(posedge ref_clk);
        set_addr(3'h0, 13'h0040);
        i_master.xfer(8'h55, 1'b0, rx, ack);
        check({7'h0, ack}, 8'h00);
        i_master.stop();
        check({7'h0, prog_busy}, 8'h00);
        inhibit <= 1'b0;
        // a stop one bit into the next byte must discard the acknowledged byte
        set_addr(3'h0, 13'h0040);
        i_master.xfer(8'h66, 1'b0, rx, ack);
        check({7'h0, ack}, 8'h01);
        i_master.bit_slot(1'b1, ack);
        i_master.stop();
        check({7'h0, prog_busy}, 8'h00);
        set_addr(3'h0, 13'h0040);
        rd_select();
        rd(8'hff, 1'b0);
    end
    endtask
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge ref_clk);
        t_refuse_blank();
        t_page();
        t_inhibit();
        test_done();
    end
    // hang guard; the whole run needs about a third of this
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            miscompares++;
            test_done();
        end
    end
endmodule // seeb_slave_tb
bind seeb_slave seeb_slave_properties #(.PROG_CYCLES(PROG_CYCLES)) i_props (.ref_clk(ref_clk), .rst_b(rst_b),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_b(sda_oe_b), .chip_select_pins(chip_select_pins),
    .write_inhibit_pin(write_inhibit_pin), .prog_busy(prog_busy));
`default_nettype wire
